//--- design/mhr_core.sv
`timescale 1ns/1ps
module mhr_core #(
  parameter int AXES = 32
) (
  input  wire logic            i_sys_clk,
  input  wire logic            i_resetn,
  input  wire logic            i_run_switch,
  input  wire logic            i_ready_select,
  input  wire logic            i_ready_setting_word_lsb,
  input  wire logic            i_ready_setting_bit,
  input  wire logic            i_test_mode_active,
  input  wire logic            i_tool_param_wr,
  input  wire logic [AXES-1:0] i_axis_moving,
  input  wire logic [AXES-1:0] i_program_start,
  input  wire logic [AXES-1:0] i_axis_done,
  input  wire logic [AXES-1:0] i_zero_speed_hold,
  input  wire logic [AXES-1:0] i_jog_forward_cmd,
  input  wire logic [AXES-1:0] i_jog_reverse_cmd,
  input  wire logic [AXES-1:0] i_handwheel_enable,
  input  wire logic [AXES-1:0] i_position_set_busy,
  input  wire logic [AXES-1:0] i_gain_switch_cmd,
  input  wire logic [AXES-1:0] i_pid_select_cmd,
  input  wire logic [AXES-1:0] i_loop_select_cmd,
  input  wire logic [AXES-1:0] i_full_loop_capable,
  input  wire logic [AXES-1:0] i_amp_started,
  input  wire logic [AXES-1:0] i_link_broken,
  input  wire logic [AXES-1:0] i_amp_ctrl_power_lost,
  input  wire logic [AXES-1:0] i_completion_wait,
  input  wire logic [AXES-1:0] i_completion_ack,
  input  wire logic [AXES-1:0] i_aux_code_out,
  output logic                 o_host_ready_flag,
  output logic                 o_motion_ready_done,
  output logic                 o_motion_enable,
  output logic                 o_tool_wr_accept,
  output logic                 o_tool_wr_reject,
  output logic                 o_rise_error,
  output logic                 o_clear_aux_codes,
  output logic                 o_start_auto_programs,
  output logic                 o_stop_all,
  output logic [AXES-1:0]      o_axis_start_accepted,
  output logic [AXES-1:0]      o_gain_alt,
  output logic [AXES-1:0]      o_pid_mode,
  output logic [AXES-1:0]      o_full_loop,
  output logic [AXES-1:0]      o_aux_code_pending,
  output logic [AXES-1:0]      o_completion_ack_valid
);
  // refused at elaboration, the flag vector cannot serve more axes
  if (AXES < 1 || AXES > mhr_pkg::MAX_AXES)
  begin
    $error("AXES out of range");
  end

  localparam int SYNC_TOP = mhr_pkg::SYNC_LEN - 1;
  localparam int SYNC_MID = mhr_pkg::SYNC_LEN - 2;

  // run switch and ready setting pins cross into the clock domain through three stages
  logic [mhr_pkg::SYNC_LEN-1:0] run_sync_ff, nxt_run_sync;
  logic [mhr_pkg::SYNC_LEN-1:0] rsw_sync_ff, nxt_rsw_sync;
  logic [mhr_pkg::SYNC_LEN-1:0] rsb_sync_ff, nxt_rsb_sync;
  logic run_ok, rsw_ok, rsb_ok;
  logic run_ff, nxt_run, rset_ff, nxt_rset;
  logic hr_ff, nxt_hr, done_ff, nxt_done;
  logic err_ff, nxt_err, clr_ff, nxt_clr, auto_ff, nxt_auto, stop_ff, nxt_stop;
  logic rej_ff, nxt_rej, acc_ff, nxt_acc;
  mhr_pkg::mhr_state_t st_ff, nxt_st;
  logic rset_now, run_now;

  always_comb
  begin
    nxt_run_sync = {run_sync_ff[mhr_pkg::SYNC_LEN-2:0], i_run_switch};
    nxt_rsw_sync = {rsw_sync_ff[mhr_pkg::SYNC_LEN-2:0], i_ready_setting_word_lsb};
    nxt_rsb_sync = {rsb_sync_ff[mhr_pkg::SYNC_LEN-2:0], i_ready_setting_bit};
    // a change counts once last two stages agree
    run_ok  = run_sync_ff[SYNC_TOP] == run_sync_ff[SYNC_MID];
    rsw_ok  = rsw_sync_ff[SYNC_TOP] == rsw_sync_ff[SYNC_MID];
    rsb_ok  = rsb_sync_ff[SYNC_TOP] == rsb_sync_ff[SYNC_MID];
    nxt_run  = run_ok ? run_sync_ff[SYNC_TOP] : run_ff;
    rset_now = (rsw_ok ? rsw_sync_ff[SYNC_TOP] : 1'b0) | (rsb_ok ? rsb_sync_ff[SYNC_TOP] : 1'b0);
    nxt_rset = (rsw_ok && rsb_ok) ? rset_now : rset_ff;
    run_now  = nxt_run;
    nxt_hr   = hr_ff;
    if (!run_now)
    begin
      nxt_hr = 1'b0;
    end
    else if (i_ready_select == mhr_pkg::SEL_RUN_SWITCH[0])
    begin
      nxt_hr = 1'b1;
    end
    else if (nxt_rset && !rset_ff)
    begin
      nxt_hr = 1'b1;
    end
    else if (!nxt_rset && rset_ff)
    begin
      nxt_hr = 1'b0;
    end
  end

  logic hr_rise, hr_fall;
  always_comb
  begin
    hr_rise  = hr_ff && !o_host_ready_flag;
    hr_fall  = !hr_ff && o_host_ready_flag;
    nxt_st   = st_ff;
    nxt_done = done_ff;
    nxt_err  = 1'b0;
    nxt_clr  = 1'b0;
    nxt_auto = 1'b0;
    nxt_stop = 1'b0;
    case (st_ff)
      mhr_pkg::HR_IDLE:
      begin
        if (hr_rise)
        begin
          nxt_st = i_test_mode_active ? mhr_pkg::HR_DEFERRED : mhr_pkg::HR_ACTIVE;
        end
      end
      mhr_pkg::HR_DEFERRED:
      begin
        if (!hr_ff)
        begin
          nxt_st = mhr_pkg::HR_IDLE;
        end
        else if (!i_test_mode_active)
        begin
          nxt_st = mhr_pkg::HR_ACTIVE;
        end
      end
      mhr_pkg::HR_ACTIVE:
      begin
        if (!hr_ff)
        begin
          nxt_st = mhr_pkg::HR_IDLE;
        end
      end
      default:
      begin
        nxt_st = mhr_pkg::HR_IDLE;
      end
    endcase
    // rise processing runs on entering active
    if (nxt_st == mhr_pkg::HR_ACTIVE && st_ff != mhr_pkg::HR_ACTIVE)
    begin
      if (|i_axis_moving)
      begin
        nxt_err = 1'b1;
      end
      else
      begin
        nxt_clr  = 1'b1;
        nxt_auto = 1'b1;
        nxt_done = 1'b1;
      end
    end
    if (hr_fall)
    begin
      nxt_done = 1'b0;
      nxt_stop = 1'b1;
    end
    nxt_rej = i_tool_param_wr && hr_ff;
    nxt_acc = i_tool_param_wr && !hr_ff;
  end

  // all flags reset unconditionally, nothing retained
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      run_sync_ff <= '0;
      rsw_sync_ff <= '0;
      rsb_sync_ff <= '0;
      run_ff      <= 1'b0;
      rset_ff     <= 1'b0;
      hr_ff       <= 1'b0;
      o_host_ready_flag <= 1'b0;
      st_ff       <= mhr_pkg::HR_IDLE;
      done_ff     <= 1'b0;
      err_ff      <= 1'b0;
      clr_ff      <= 1'b0;
      auto_ff     <= 1'b0;
      stop_ff     <= 1'b0;
      rej_ff      <= 1'b0;
      acc_ff      <= 1'b0;
    end
    else
    begin
      run_sync_ff <= nxt_run_sync;
      rsw_sync_ff <= nxt_rsw_sync;
      rsb_sync_ff <= nxt_rsb_sync;
      run_ff      <= nxt_run;
      rset_ff     <= nxt_rset;
      hr_ff       <= nxt_hr;
      o_host_ready_flag <= hr_ff;
      st_ff       <= nxt_st;
      done_ff     <= nxt_done;
      err_ff      <= nxt_err;
      clr_ff      <= nxt_clr;
      auto_ff     <= nxt_auto;
      stop_ff     <= nxt_stop;
      rej_ff      <= nxt_rej;
      acc_ff      <= nxt_acc;
    end
  end

  assign o_motion_ready_done   = done_ff;
  assign o_rise_error          = err_ff;
  assign o_clear_aux_codes     = clr_ff;
  assign o_start_auto_programs = auto_ff;
  assign o_stop_all            = stop_ff;
  assign o_tool_wr_reject      = rej_ff;
  assign o_tool_wr_accept      = acc_ff;
  // handshake level, combinational on purpose
  assign o_motion_enable = o_host_ready_flag && !i_test_mode_active;

  // per axis flags
  logic [AXES-1:0] sa_ff, nxt_sa, gain_ff, pid_ff, loop_ff, nxt_loop, pend_ff, ackv_ff;
  logic [AXES-1:0] jog_seen_ff, nxt_jog_seen;
  logic [AXES-1:0] hold_ff, nxt_hold;
  always_comb
  begin
    nxt_sa       = sa_ff;
    nxt_jog_seen = jog_seen_ff;
    nxt_loop     = loop_ff;
    nxt_hold     = i_handwheel_enable | i_position_set_busy;
    for (int a = 0; a < AXES; a++)
    begin
      if (i_axis_done[a] && !i_zero_speed_hold[a])
      begin
        nxt_sa[a] = 1'b0;
      end
      if (i_jog_forward_cmd[a] || i_jog_reverse_cmd[a])
      begin
        nxt_jog_seen[a] = 1'b1;
      end
      else if (jog_seen_ff[a] && !i_axis_moving[a])
      begin
        nxt_jog_seen[a] = 1'b0;
        nxt_sa[a]       = 1'b0;
      end
      // clear only on the drop of the holding source, so a running program keeps its flag
      if (hold_ff[a] && !nxt_hold[a])
      begin
        nxt_sa[a] = 1'b0;
      end
      // starts win over clears in the same cycle
      if (o_motion_enable && (i_program_start[a] || i_jog_forward_cmd[a] || i_jog_reverse_cmd[a]
          || i_handwheel_enable[a] || i_position_set_busy[a]))
      begin
        nxt_sa[a] = 1'b1;
      end
      if (i_link_broken[a] || i_amp_ctrl_power_lost[a] || !i_full_loop_capable[a])
      begin
        nxt_loop[a] = 1'b0;
      end
      else if (i_amp_started[a])
      begin
        nxt_loop[a] = i_loop_select_cmd[a];
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      sa_ff       <= '0;
      jog_seen_ff <= '0;
      hold_ff     <= '0;
      gain_ff     <= '0;
      pid_ff      <= '0;
      loop_ff     <= '0;
      pend_ff     <= '0;
      ackv_ff     <= '0;
    end
    else
    begin
      sa_ff       <= nxt_sa;
      jog_seen_ff <= nxt_jog_seen;
      hold_ff     <= nxt_hold;
      gain_ff     <= i_gain_switch_cmd;
      pid_ff      <= i_pid_select_cmd;
      loop_ff     <= nxt_loop;
      pend_ff     <= i_aux_code_out & i_completion_wait;
      ackv_ff     <= i_completion_ack & i_completion_wait;
    end
  end

  assign o_axis_start_accepted  = sa_ff;
  assign o_gain_alt             = gain_ff;
  assign o_pid_mode             = pid_ff;
  assign o_full_loop            = loop_ff;
  assign o_aux_code_pending     = pend_ff;
  assign o_completion_ack_valid = ackv_ff;

  hr_fall_stop_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    $fell(o_host_ready_flag) |-> o_stop_all && !o_motion_ready_done)
    else $error("fall did not stop");
  rise_error_skip_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_rise_error |-> !o_start_auto_programs && !o_clear_aux_codes)
    else $error("error rise still processed");
  rise_process_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_start_auto_programs |-> o_clear_aux_codes && o_motion_ready_done && o_host_ready_flag)
    else $error("rise processing incomplete");
  test_defer_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_test_mode_active && $past(i_test_mode_active)) |-> !o_start_auto_programs)
    else $error("rise processed during test mode");
  motion_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    ((o_axis_start_accepted & ~$past(o_axis_start_accepted)) != '0) |-> $past(o_motion_enable))
    else $error("motion without host ready");
  tool_reject_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_tool_param_wr && hr_ff) |=> o_tool_wr_reject && !o_tool_wr_accept)
    else $error("tool write not rejected");
  pending_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_aux_code_pending & ~$past(i_completion_wait)) == '0)
    else $error("pending without completion wait");
  loop_fallback_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    ((o_full_loop & $past(i_link_broken | i_amp_ctrl_power_lost)) == '0))
    else $error("full loop kept after link loss");
  gain_follow_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    ##1 o_gain_alt == $past(i_gain_switch_cmd))
    else $error("gain request mismatch");
  cv_rise: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) o_start_auto_programs);
  cv_err: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) o_rise_error);
  cv_defer: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) st_ff == mhr_pkg::HR_DEFERRED);
  cv_stop: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) o_stop_all);
endmodule

//--- design/mhr_pkg.sv
// How it works
// - gain switch command high requests alternate gain, low requests normal gain
// - PID select high gives PID regulation, low gives PI regulation
// - on capable amplifiers loop select high gives full closed loop, low semi
// - loop select changes ignored while amplifier still starting up
// - reset, link break or amplifier control power loss force semi closed loop
// - completion wait and pending output live only with completion-wait acceleration
// - positioning flags never retained over reset
// - motion only while host-ready asserted
// - test mode blocks host commanded motion even with host-ready
// - tool parameter writes rejected while host-ready asserted
// - host-ready rise clears aux codes, sets ready-done, restarts auto programs
// - any axis moving at rise raises error and skips rise processing
// - rise during test mode deferred until test mode ends with host-ready still high
// - host-ready fall clears ready-done, stops axes, halts programs, outputs low
// - default selection: host-ready follows run switch
// - alternate selection: host-ready follows ready bit edges while in run
// - program start sets named axes accepted; clear at completion or stop
// - stop by zero speed change keeps accepted flag set
// - jog motion sets accepted; clears when motion stops after jog released
// - handwheel enable holds accepted set; deassert clears it
// - position set holds accepted set until it completes
// - one accepted flag per axis, up to 32 axes
package mhr_pkg;
  localparam int MAX_AXES = 32;
  localparam int SYNC_LEN = 3;
  localparam logic [1:0] SEL_RUN_SWITCH = 2'h0;
  localparam logic [1:0] SEL_READY_SET  = 2'h1;
  typedef enum logic [1:0]
  {
    HR_IDLE     = 2'b00,
    HR_DEFERRED = 2'b01,
    HR_ACTIVE   = 2'b10
  } mhr_state_t;
endpackage

//--- sim/mhr_host_model.sv
`timescale 1ns/1ps
// host side: run switch, ready source and test mode, changed just after an edge
// never touches the accepted flags, those stay device owned
module mhr_host_model (
  input  wire logic i_sys_clk,
  input  wire logic i_resetn,
  input  wire logic i_want_run,
  input  wire logic i_want_sel,
  input  wire logic i_want_bit,
  input  wire logic i_use_word,
  input  wire logic i_want_test,
  output logic      o_run_switch,
  output logic      o_ready_select,
  output logic      o_ready_word_lsb,
  output logic      o_ready_bit,
  output logic      o_test_mode
);
  always_ff @(posedge i_sys_clk)
  begin
    o_run_switch     <= i_resetn & i_want_run;
    o_ready_select   <= i_resetn & i_want_sel;
    o_ready_word_lsb <= i_resetn & i_want_bit & i_use_word;
    o_ready_bit      <= i_resetn & i_want_bit & ~i_use_word;
    o_test_mode      <= i_resetn & i_want_test;
  end
endmodule

//--- sim/test_motion_host_ready_start_accept.sv
`timescale 1ns/1ps
module test_motion_host_ready_start_accept;
  localparam int AX = 4;
  logic          i_sys_clk, i_resetn, i_tool_param_wr, i_run_switch, i_ready_select;
  logic          i_ready_setting_word_lsb, i_ready_setting_bit, i_test_mode_active;
  logic          want_run, want_sel, want_bit, use_word, want_test;
  logic [AX-1:0] i_axis_moving, i_program_start, i_axis_done, i_zero_speed_hold, i_jog_forward_cmd;
  logic [AX-1:0] i_jog_reverse_cmd, i_handwheel_enable, i_position_set_busy, i_gain_switch_cmd;
  logic [AX-1:0] i_pid_select_cmd, i_loop_select_cmd, i_full_loop_capable, i_amp_started, i_link_broken;
  logic [AX-1:0] i_amp_ctrl_power_lost, i_completion_wait, i_completion_ack, i_aux_code_out;
  logic          o_host_ready_flag, o_motion_ready_done, o_motion_enable, o_tool_wr_accept, o_tool_wr_reject;
  logic          o_rise_error, o_clear_aux_codes, o_start_auto_programs, o_stop_all;
  logic [AX-1:0] o_axis_start_accepted, o_gain_alt, o_pid_mode, o_full_loop, o_aux_code_pending;
  logic [AX-1:0] o_completion_ack_valid, exp_fl;
  logic [31:0]   seed, r;
  int            bad_count, tests_run;

  mhr_core #(.AXES(AX)) u_dut (.i_sys_clk, .i_resetn, .i_run_switch, .i_ready_select, .i_ready_setting_word_lsb,
    .i_ready_setting_bit, .i_test_mode_active, .i_tool_param_wr, .i_axis_moving, .i_program_start, .i_axis_done,
    .i_zero_speed_hold, .i_jog_forward_cmd, .i_jog_reverse_cmd, .i_handwheel_enable, .i_position_set_busy,
    .i_gain_switch_cmd, .i_pid_select_cmd, .i_loop_select_cmd, .i_full_loop_capable, .i_amp_started,
    .i_link_broken, .i_amp_ctrl_power_lost, .i_completion_wait, .i_completion_ack, .i_aux_code_out,
    .o_host_ready_flag, .o_motion_ready_done, .o_motion_enable, .o_tool_wr_accept, .o_tool_wr_reject,
    .o_rise_error, .o_clear_aux_codes, .o_start_auto_programs, .o_stop_all, .o_axis_start_accepted,
    .o_gain_alt, .o_pid_mode, .o_full_loop, .o_aux_code_pending, .o_completion_ack_valid);

  mhr_host_model u_host (.i_sys_clk, .i_resetn, .i_want_run(want_run), .i_want_sel(want_sel),
    .i_want_bit(want_bit), .i_use_word(use_word), .i_want_test(want_test), .o_run_switch(i_run_switch),
    .o_ready_select(i_ready_select), .o_ready_word_lsb(i_ready_setting_word_lsb),
    .o_ready_bit(i_ready_setting_bit), .o_test_mode(i_test_mode_active));

  initial
  begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // loop select only lands on a started amplifier, every fault falls back to semi
  function automatic logic [AX-1:0] fl_next(input logic [AX-1:0] held);
    return (i_amp_started & i_loop_select_cmd | ~i_amp_started & held)
      & i_full_loop_capable & ~i_link_broken & ~i_amp_ctrl_power_lost;
  endfunction

  task automatic complete_run();
    $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  // 0: ready high, 1: ready low, 2: auto start pulse
  task automatic wait_on(input int s);
    int n;
    n = 0;
    while ((s == 2 ? o_start_auto_programs : o_host_ready_flag == (s == 0)) !== 1'b1 && n < 20)
    begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    if (n == 20)
    begin
      bad_count++;
      complete_run();
    end
  endtask

  task automatic tool_wr(input logic [1:0] exp);
    tick(1);
    i_tool_param_wr <= 1'b1;
    tick(1);
    i_tool_param_wr <= 1'b0;
    #1;
    chk({o_tool_wr_accept, o_tool_wr_reject}, exp);
  endtask

  initial
  begin
    bad_count = 0;
    tests_run = 0;
    seed = 32'h0000002C;
    exp_fl = '0;
    i_resetn = 1'b0;
    {i_tool_param_wr, want_run, want_sel, want_bit, use_word, want_test} = '0;
    {i_axis_moving, i_program_start, i_axis_done, i_zero_speed_hold, i_jog_forward_cmd, i_jog_reverse_cmd} = '0;
    {i_handwheel_enable, i_position_set_busy, i_gain_switch_cmd, i_pid_select_cmd, i_loop_select_cmd} = '0;
    {i_full_loop_capable, i_amp_started, i_link_broken, i_amp_ctrl_power_lost} = '0;
    {i_completion_wait, i_completion_ack, i_aux_code_out} = '0;
    tick(4);
    i_resetn <= 1'b1;
    #1;
    chk({o_host_ready_flag, o_motion_ready_done, o_axis_start_accepted, o_full_loop}, '0);
    tool_wr(2'h2);
    tick(1);
    i_axis_moving <= 4'h2;
    want_run <= 1'b1;
    wait_on(0);
    chk({o_rise_error, o_start_auto_programs, o_clear_aux_codes, o_motion_ready_done}, 4'h8);
    tick(1);
    i_axis_moving <= '0;
    want_run <= 1'b0;
    wait_on(1);
    tick(1);
    want_test <= 1'b1;
    want_run <= 1'b1;
    wait_on(0);
    tick(1);
    i_program_start <= 4'hF;
    #1;
    chk({o_start_auto_programs, o_motion_enable}, 2'h0);
    tick(1);
    i_program_start <= '0;
    #1;
    chk(o_axis_start_accepted, 4'h0);
    tool_wr(2'h1);
    tick(1);
    want_test <= 1'b0;
    wait_on(2);
    chk({o_clear_aux_codes, o_motion_ready_done, o_motion_enable}, 3'h7);
    tick(1);
    i_program_start <= 4'hF;
    i_zero_speed_hold <= 4'h4;
    tick(1);
    i_program_start <= '0;
    i_axis_done <= 4'h5;
    #1;
    chk(o_axis_start_accepted, 4'hF);
    tick(1);
    i_axis_done <= 4'hA;
    #1;
    chk(o_axis_start_accepted, 4'hE);
    tick(1);
    i_axis_done <= '0;
    i_jog_forward_cmd <= 4'h1;
    i_jog_reverse_cmd <= 4'h2;
    i_handwheel_enable <= 4'h4;
    i_position_set_busy <= 4'h8;
    i_axis_moving <= 4'h3;
    #1;
    chk(o_axis_start_accepted, 4'h4);
    tick(1);
    {i_jog_forward_cmd, i_jog_reverse_cmd, i_handwheel_enable, i_position_set_busy} <= '0;
    #1;
    chk(o_axis_start_accepted, 4'hF);
    tick(1);
    i_axis_moving <= '0;
    #1;
    chk(o_axis_start_accepted, 4'h3);
    tick(1);
    #1;
    chk(o_axis_start_accepted, 4'h0);
    for (int k = 0; k < 40; k++)
    begin
      tick(1);
      seed = xs(seed);
      r = xs(seed);
      {i_gain_switch_cmd, i_pid_select_cmd, i_loop_select_cmd, i_full_loop_capable, i_amp_started} <= seed[19:0];
      i_link_broken <= seed[23:20] & seed[27:24];
      i_amp_ctrl_power_lost <= seed[31:28] & r[15:12];
      {i_completion_wait, i_completion_ack, i_aux_code_out} <= r[11:0];
      tick(1);
      #1;
      exp_fl = fl_next(exp_fl);
      chk(o_gain_alt, i_gain_switch_cmd);
      chk(o_pid_mode, i_pid_select_cmd);
      chk(o_full_loop, exp_fl);
      chk(o_aux_code_pending, i_aux_code_out & i_completion_wait);
      chk(o_completion_ack_valid, i_completion_ack & i_completion_wait);
    end
    tick(1);
    want_run <= 1'b0;
    wait_on(1);
    chk({o_stop_all, o_motion_ready_done, o_motion_enable}, 3'h4);
    tick(1);
    want_sel <= 1'b1;
    want_run <= 1'b1;
    tick(8);
    #1;
    chk(o_host_ready_flag, 1'b0);
    tick(1);
    use_word <= 1'b1;
    want_bit <= 1'b1;
    wait_on(0);
    chk({o_start_auto_programs, o_clear_aux_codes, o_motion_ready_done}, 3'h7);
    tick(1);
    want_bit <= 1'b0;
    wait_on(1);
    chk({o_stop_all, o_motion_ready_done}, 2'h2);
    tick(1);
    use_word <= 1'b0;
    want_bit <= 1'b1;
    wait_on(0);
    tick(1);
    want_run <= 1'b0;
    wait_on(1);
    chk(o_host_ready_flag, 1'b0);
    complete_run();
  end
endmodule
